// >>> design/nco_block.sv
// numerically controlled oscillator with an avalon-mm register slave
//
// What this block does
// - oscillator advances only while the on bit (control bit 7) is set
// - control bit 5 reads back the present output level, read only
// - output invert bit (control bit 4) makes the output active low
// - control bit 0 set selects pulse mode, clear selects toggle mode
// - pulse width code in bits 7:5 gives 2**code clock periods, 1 to 128
// - clock code bits 1:0: fast oscillator, system clock, logic cell three
// - pulse width code matters only in pulse mode
// - accumulator is three byte registers, bits 7:0, 15:8, 19:16
// - step value is three byte registers, bits 7:0, 15:8, 19:16
// - unimplemented register bits read as zero
// - each selected clock edge adds step to accumulator; carry is overflow
// - toggle mode flips the output on every overflow
// - pulse mode drives output active after overflow for the chosen width
// - enabled: low step write loads buffer on second tick; disabled: at once
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module nco_block
    import osc_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // clock sources from outside this domain
    input  wire logic        i_internal_fast_oscillator,
    input  wire logic        i_logic_cell_three_output,
    // avalon-mm slave
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output var  logic [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // oscillator output and interrupt
    output logic             o_osc_out,
    output logic             o_irq
);

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    osc_ctl_t          ctl_q;
    logic [ACC_W-1:0]  acc_q;
    logic [ACC_W-1:0]  step_reg_q;
    logic [ACC_W-1:0]  step_buf_q;
    logic [1:0]        load_cnt_q;
    logic              load_now_q;
    logic              raw_q;
    logic [7:0]        width_cnt_q;
    logic              ovf_flag_q;
    logic              ovf_en_q;
    logic              ack_q;
    logic [2:0]        fast_sync_q;
    logic [2:0]        lc3_sync_q;
    logic              tick;
    logic              advance;
    logic [ACC_W:0]    sum;
    logic              carry;
    logic              wr_en;
    logic              rd_en;
    logic [7:0]        wbyte;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
        is_addr = (a == r);
    endfunction : is_addr

    // pulse length minus one, in ticks
    function automatic logic [7:0] pulse_last(input logic [2:0] code);
        pulse_last = (PULSE_ONE << code) - PULSE_ONE;
    endfunction : pulse_last

    // ---------------------------------------------------------------
    // bus handshake: one wait cycle, answer on the second edge
    // ---------------------------------------------------------------
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
    assign wr_en             = i_avs_write & ack_q & i_avs_byteenable[0];
    assign rd_en             = i_avs_read & ~ack_q;
    assign wbyte             = i_avs_writedata[7:0];

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
        end
    end

    // ---------------------------------------------------------------
    // input clock selection
    // ---------------------------------------------------------------
    // foreign clocks are sampled, so they must stay below half of i_clk
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            fast_sync_q <= 3'h0;
            lc3_sync_q  <= 3'h0;
        end else begin
            fast_sync_q <= {fast_sync_q[1:0], i_internal_fast_oscillator};
            lc3_sync_q  <= {lc3_sync_q[1:0], i_logic_cell_three_output};
        end
    end

    always_comb begin
        case (ctl_q.input_clock_code)
            SRC_FAST_OSC: tick = fast_sync_q[1] & ~fast_sync_q[2];
            SRC_SYS_CLK:  tick = 1'b1;
            SRC_LC3:      tick = lc3_sync_q[1] & ~lc3_sync_q[2];
            default:      tick = 1'b0;
        endcase
    end

    assign advance = tick & ctl_q.osc_on;
    assign sum     = {1'b0, acc_q} + {1'b0, step_buf_q};
    assign carry   = advance & sum[ACC_W];

    // ---------------------------------------------------------------
    // control and clock select registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ctl_q <= CTL_RESET;
        end else if (wr_en && is_addr(i_avs_address, ADDR_CONTROL)) begin
            ctl_q.osc_on            <= wbyte[CTL_ON_BIT];
            ctl_q.output_invert     <= wbyte[CTL_INVERT_BIT];
            ctl_q.pulse_mode_select <= wbyte[CTL_PULSE_BIT];
        end else if (wr_en && is_addr(i_avs_address, ADDR_CLOCK_SEL)) begin
            ctl_q.pulse_width_code <= wbyte[CLK_PWC_LSB +: 3];
            ctl_q.input_clock_code <= clk_src_t'(wbyte[CLK_ICC_LSB +: 2]);
        end
    end

    // ---------------------------------------------------------------
    // phase accumulator: software write beats the running sum
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            acc_q <= ACC_RESET;
        end else if (wr_en && is_addr(i_avs_address, ADDR_ACC_LOW)) begin
            acc_q[7:0] <= wbyte;
        end else if (wr_en && is_addr(i_avs_address, ADDR_ACC_HIGH)) begin
            acc_q[15:8] <= wbyte;
        end else if (wr_en && is_addr(i_avs_address, ADDR_ACC_UPPER)) begin
            acc_q[19:16] <= wbyte[3:0];
        end else if (advance) begin
            acc_q <= sum[ACC_W-1:0];
        end
    end

    // ---------------------------------------------------------------
    // step value and its double buffer
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            step_reg_q <= STEP_RESET;
        end else if (wr_en && is_addr(i_avs_address, ADDR_INC_LOW)) begin
            step_reg_q[7:0] <= wbyte;
        end else if (wr_en && is_addr(i_avs_address, ADDR_INC_HIGH)) begin
            step_reg_q[15:8] <= wbyte;
        end else if (wr_en && is_addr(i_avs_address, ADDR_INC_UPPER)) begin
            step_reg_q[19:16] <= wbyte[3:0];
        end
    end

    // buffer copies all bytes at once, so a half-written step never runs
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            load_now_q <= 1'b0;
        end else begin
            load_now_q <= wr_en && !ctl_q.osc_on
                       && (is_addr(i_avs_address, ADDR_INC_LOW)
                        || is_addr(i_avs_address, ADDR_INC_HIGH)
                        || is_addr(i_avs_address, ADDR_INC_UPPER));
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            load_cnt_q <= 2'h0;
        end else if (wr_en && ctl_q.osc_on && is_addr(i_avs_address, ADDR_INC_LOW)) begin
            load_cnt_q <= LOAD_DELAY;
        end else if (load_cnt_q != 2'h0 && advance) begin
            load_cnt_q <= load_cnt_q - 2'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            step_buf_q <= STEP_RESET;
        end else if (load_now_q || (load_cnt_q == 2'h1 && advance)) begin
            step_buf_q <= step_reg_q;
        end
    end

    // ---------------------------------------------------------------
    // output shaping
    // ---------------------------------------------------------------
    // a pulse longer than the overflow period simply restarts; undefined by use
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            raw_q       <= 1'b0;
            width_cnt_q <= 8'h00;
        end else if (!ctl_q.pulse_mode_select) begin
            width_cnt_q <= 8'h00;
            if (carry) begin
                raw_q <= ~raw_q;
            end
        end else if (carry) begin
            raw_q       <= 1'b1;
            width_cnt_q <= pulse_last(ctl_q.pulse_width_code);
        end else if (advance && raw_q) begin
            if (width_cnt_q == 8'h00) begin
                raw_q <= 1'b0;
            end else begin
                width_cnt_q <= width_cnt_q - 8'h01;
            end
        end
    end

    assign o_osc_out = raw_q ^ ctl_q.output_invert;

    // ---------------------------------------------------------------
    // interrupt status, enable and clear
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ovf_flag_q <= 1'b0;
        end else if (carry) begin
            ovf_flag_q <= 1'b1;
        end else if (wr_en && is_addr(i_avs_address, ADDR_IRQ_CLR)
                     && wbyte[IRQ_OVF_BIT]) begin
            ovf_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ovf_en_q <= 1'b0;
        end else if (wr_en && is_addr(i_avs_address, ADDR_IRQ_EN)) begin
            ovf_en_q <= wbyte[IRQ_OVF_BIT];
        end
    end

    assign o_irq = ovf_flag_q & ovf_en_q;

    // ---------------------------------------------------------------
    // read data, captured in the wait cycle
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (rd_en) begin
            o_avs_readdata <= 32'h0000_0000;
            if (is_addr(i_avs_address, ADDR_CONTROL)) begin
                o_avs_readdata[CTL_ON_BIT]     <= ctl_q.osc_on;
                o_avs_readdata[CTL_LEVEL_BIT]  <= o_osc_out;
                o_avs_readdata[CTL_INVERT_BIT] <= ctl_q.output_invert;
                o_avs_readdata[CTL_PULSE_BIT]  <= ctl_q.pulse_mode_select;
            end else if (is_addr(i_avs_address, ADDR_CLOCK_SEL)) begin
                o_avs_readdata[CLK_PWC_LSB +: 3] <= ctl_q.pulse_width_code;
                o_avs_readdata[CLK_ICC_LSB +: 2] <= ctl_q.input_clock_code;
            end else if (is_addr(i_avs_address, ADDR_ACC_LOW)) begin
                o_avs_readdata[7:0] <= acc_q[7:0];
            end else if (is_addr(i_avs_address, ADDR_ACC_HIGH)) begin
                o_avs_readdata[7:0] <= acc_q[15:8];
            end else if (is_addr(i_avs_address, ADDR_ACC_UPPER)) begin
                o_avs_readdata[3:0] <= acc_q[19:16];
            end else if (is_addr(i_avs_address, ADDR_INC_LOW)) begin
                o_avs_readdata[7:0] <= step_reg_q[7:0];
            end else if (is_addr(i_avs_address, ADDR_INC_HIGH)) begin
                o_avs_readdata[7:0] <= step_reg_q[15:8];
            end else if (is_addr(i_avs_address, ADDR_INC_UPPER)) begin
                o_avs_readdata[3:0] <= step_reg_q[19:16];
            end else if (is_addr(i_avs_address, ADDR_IRQ_STAT)) begin
                o_avs_readdata[IRQ_OVF_BIT] <= ovf_flag_q;
            end else if (is_addr(i_avs_address, ADDR_IRQ_EN)) begin
                o_avs_readdata[IRQ_OVF_BIT] <= ovf_en_q;
            end
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    logic acc_wr;
    assign acc_wr = wr_en && (is_addr(i_avs_address, ADDR_ACC_LOW)
                           || is_addr(i_avs_address, ADDR_ACC_HIGH)
                           || is_addr(i_avs_address, ADDR_ACC_UPPER));

    sequence s_low_step_write;
        wr_en && ctl_q.osc_on && is_addr(i_avs_address, ADDR_INC_LOW);
    endsequence

    sequence s_first_tick;
        load_cnt_q == LOAD_DELAY && advance;
    endsequence

    AST_HOLD_WHEN_OFF: assert property (!ctl_q.osc_on && !acc_wr |=> $stable(acc_q))
        else $error("accumulator moved while oscillator off");

    AST_LEVEL_READBACK: assert property (rd_en && is_addr(i_avs_address, ADDR_CONTROL)
        |=> o_avs_readdata[CTL_LEVEL_BIT] == $past(o_osc_out))
        else $error("level readback differs from output");

    AST_INVERT: assert property ($rose(ctl_q.output_invert) && $stable(raw_q)
        |-> o_osc_out != $past(o_osc_out))
        else $error("invert change did not flip the output");

    AST_TOGGLE: assert property (carry && !ctl_q.pulse_mode_select
        |=> raw_q != $past(raw_q))
        else $error("toggle mode missed an overflow");

    AST_PULSE_START: assert property (carry && ctl_q.pulse_mode_select
        |=> raw_q && width_cnt_q == pulse_last($past(ctl_q.pulse_width_code)))
        else $error("pulse did not start after overflow");

    AST_SUM: assert property (advance && !acc_wr
        |=> acc_q == $past(sum[ACC_W-1:0]))
        else $error("accumulator did not add step");

    AST_DEFERRED_LOAD: assert property (s_low_step_write ##1 (!wr_en throughout s_first_tick)
        |=> load_cnt_q == 2'h1)
        else $error("load delay did not count the first tick");

    AST_FLAG_SET: assert property (carry |=> ovf_flag_q)
        else $error("overflow flag not set");

    AST_RESERVED_ZERO: assert property (rd_en && is_addr(i_avs_address, ADDR_ACC_UPPER)
        |=> o_avs_readdata[31:4] == 28'h0000000)
        else $error("unimplemented bits read nonzero");

    AST_FDC_NO_WIDTH: assert property (!ctl_q.pulse_mode_select |=> width_cnt_q == 8'h00)
        else $error("width counter active in toggle mode");

endmodule : nco_block

`default_nettype wire

// >>> design/osc_pkg.sv
// package: register map, field layout and constants of the oscillator block
package osc_pkg;

    // ---------------------------------------------------------------
    // register byte addresses (one aligned word each)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL   = 8'h00;
    localparam logic [7:0] ADDR_CLOCK_SEL = 8'h04;
    localparam logic [7:0] ADDR_ACC_LOW   = 8'h08;
    localparam logic [7:0] ADDR_ACC_HIGH  = 8'h0c;
    localparam logic [7:0] ADDR_ACC_UPPER = 8'h10;
    localparam logic [7:0] ADDR_INC_LOW   = 8'h14;
    localparam logic [7:0] ADDR_INC_HIGH  = 8'h18;
    localparam logic [7:0] ADDR_INC_UPPER = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h20;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h24;
    localparam logic [7:0] ADDR_IRQ_CLR   = 8'h28;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CTL_ON_BIT     = 7;
    localparam int CTL_LEVEL_BIT  = 5;
    localparam int CTL_INVERT_BIT = 4;
    localparam int CTL_PULSE_BIT  = 0;
    localparam int CLK_PWC_LSB    = 5;
    localparam int CLK_ICC_LSB    = 0;
    localparam int IRQ_OVF_BIT    = 0;

    // ---------------------------------------------------------------
    // widths, reset values and counts
    // ---------------------------------------------------------------
    localparam int          ACC_W          = 20;
    localparam logic [19:0] ACC_RESET      = 20'h00000;
    localparam logic [19:0] STEP_RESET     = 20'h00001;
    localparam logic [1:0]  LOAD_DELAY     = 2'h2;
    localparam logic [7:0]  PULSE_ONE      = 8'h01;

    // input clock source codes
    typedef enum logic [1:0] {
        SRC_FAST_OSC = 2'h0,
        SRC_SYS_CLK  = 2'h1,
        SRC_LC3      = 2'h2,
        SRC_RESERVED = 2'h3
    } clk_src_t;

    // software controls carried together
    typedef struct packed {
        logic       osc_on;
        logic       output_invert;
        logic       pulse_mode_select;
        logic [2:0] pulse_width_code;
        clk_src_t   input_clock_code;
    } osc_ctl_t;

    localparam osc_ctl_t CTL_RESET = '{1'b0, 1'b0, 1'b0, 3'h0, SRC_FAST_OSC};

endpackage : osc_pkg

// >>> verification/numerically_controlled_oscillator_test.sv
// self-checking bench for the oscillator block and its register slave
`timescale 1ns/1ps
`default_nettype none

module numerically_controlled_oscillator_test
    import osc_pkg::*;
;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        i_clk       = 1'b0;
    logic        i_sys_rst   = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read    = 1'b0;
    logic        avs_write   = 1'b0;
    logic [31:0] avs_wdata   = 32'h0;
    logic [3:0]  avs_be      = 4'hf;
    logic [31:0] rdata;
    logic        waitreq;
    logic        osc_out;
    logic        irq;
    logic        fast_osc;
    logic        logic_cell_three_output;
    int          rise_count;
    int          mismatches  = 0;
    int          num_checks  = 0;
    int          cycles      = 0;
    logic [7:0]  q;
    logic [7:0]  q2;
    logic        lvl;
    int          n;
    int          cnt;

    always #5 i_clk = ~i_clk;

    nco_block dut (
        .i_clk                      (i_clk),
        .i_sys_rst                  (i_sys_rst),
        .i_internal_fast_oscillator (fast_osc),
        .i_logic_cell_three_output  (logic_cell_three_output),
        .i_avs_address              (avs_address),
        .i_avs_read                 (avs_read),
        .i_avs_write                (avs_write),
        .i_avs_writedata            (avs_wdata),
        .i_avs_byteenable           (avs_be),
        .o_avs_readdata             (rdata),
        .o_avs_waitrequest          (waitreq),
        .o_osc_out                  (osc_out),
        .o_irq                      (irq)
    );

    osc_consumer_model partner (
        .i_clk        (i_clk),
        .i_sys_rst    (i_sys_rst),
        .i_osc_out    (osc_out),
        .o_fast_osc   (fast_osc),
        .o_logic_cell_three_output    (logic_cell_three_output),
        .o_rise_count (rise_count)
    );

    // ----------------------------------------------------------------
    // reporting and comparison
    // ----------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    task automatic check_count(input string what, input int exp, input int got);
        num_checks++;
        if (got != exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_count

    // ----------------------------------------------------------------
    // avalon-mm master and output measurement
    // ----------------------------------------------------------------
    // waitrequest is sampled at the rising edge; the request drops only after that edge
    // no local limit: only the bench timeout ends a wait
    task automatic bus(input logic wr_en, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        avs_address <= a;
        avs_write   <= wr_en;
        avs_read    <= ~wr_en;
        avs_wdata   <= {24'h0, d};
        do begin
            @(posedge i_clk);
        end while (waitreq !== 1'b0);
        q = rdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check_byte(what, exp, q);
    endtask : rd_chk

    // length in cycles of the next complete high phase of the output
    task automatic run_len(output int len);
        int t;
        t = 0;
        len = 0;
        @(negedge i_clk);
        while (osc_out !== 1'b0 && t < 3000) begin
            @(negedge i_clk);
            t++;
        end
        while (osc_out !== 1'b1 && t < 3000) begin
            @(negedge i_clk);
            t++;
        end
        while (osc_out === 1'b1 && len < 3000) begin
            @(negedge i_clk);
            len++;
        end
    endtask : run_len

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic reset_values;
        rd_chk("control", ADDR_CONTROL, 8'h00);
        rd_chk("clock select", ADDR_CLOCK_SEL, 8'h00);
        rd_chk("acc low", ADDR_ACC_LOW, 8'h00);
        rd_chk("acc upper", ADDR_ACC_UPPER, 8'h00);
        rd_chk("step low", ADDR_INC_LOW, 8'h01);
        rd_chk("step high", ADDR_INC_HIGH, 8'h00);
        rd_chk("status", ADDR_IRQ_STAT, 8'h00);
        rd_chk("clear reg", ADDR_IRQ_CLR, 8'h00);
        rd_chk("unmapped", 8'h40, 8'h00);
    endtask : reset_values

    task automatic field_access;
        wr(ADDR_CONTROL, 8'h4e);
        rd_chk("control spare bits", ADDR_CONTROL, 8'h00);
        wr(ADDR_CLOCK_SEL, 8'hff);
        rd_chk("clock select bits", ADDR_CLOCK_SEL, 8'he3);
        wr(ADDR_ACC_LOW, 8'h12);
        wr(ADDR_ACC_HIGH, 8'h34);
        wr(ADDR_ACC_UPPER, 8'hf5);
        rd_chk("acc low rw", ADDR_ACC_LOW, 8'h12);
        // a write without its low byte lane enabled must be ignored
        avs_be <= 4'he;
        wr(ADDR_ACC_LOW, 8'h77);
        avs_be <= 4'hf;
        rd_chk("acc low masked write", ADDR_ACC_LOW, 8'h12);
        rd_chk("acc high rw", ADDR_ACC_HIGH, 8'h34);
        rd_chk("acc upper rw", ADDR_ACC_UPPER, 8'h05);
        wr(ADDR_INC_UPPER, 8'hfa);
        rd_chk("step upper rw", ADDR_INC_UPPER, 8'h0a);
    endtask : field_access

    task automatic toggle_and_buffer;
        // pulse code 7 stays set while in toggle mode
        wr(ADDR_CLOCK_SEL, 8'he1);
        wr(ADDR_INC_UPPER, 8'h04);
        wr(ADDR_INC_HIGH, 8'h00);
        wr(ADDR_INC_LOW, 8'h00);
        wr(ADDR_CONTROL, 8'h80);
        run_len(n);
        check_count("toggle high run", 4, n);
        rd_chk("overflow flag", ADDR_IRQ_STAT, 8'h01);
        // upper byte first, the low byte write arms the load
        wr(ADDR_INC_UPPER, 8'h08);
        run_len(n);
        check_count("step held before low write", 4, n);
        wr(ADDR_INC_LOW, 8'h00);
        repeat (8) @(posedge i_clk);
        run_len(n);
        check_count("step after low write", 2, n);
    endtask : toggle_and_buffer

    task automatic readback_and_invert;
        wr(ADDR_CONTROL, 8'h00);
        @(negedge i_clk);
        lvl = osc_out;
        rd_chk("level readback", ADDR_CONTROL, {2'b00, lvl, 5'h00});
        cnt = rise_count;
        bus(1'b0, ADDR_ACC_UPPER, 8'h00);
        q2 = q;
        repeat (50) @(posedge i_clk);
        check_count("edges while off", cnt, rise_count);
        rd_chk("acc frozen while off", ADDR_ACC_UPPER, q2);
        wr(ADDR_CONTROL, 8'h10);
        @(negedge i_clk);
        check_byte("inverted output", {7'h0, ~lvl}, {7'h0, osc_out});
        rd_chk("inverted readback", ADDR_CONTROL, {2'b00, ~lvl, 5'h10});
        wr(ADDR_CONTROL, 8'h00);
    endtask : readback_and_invert

    task automatic pulse_widths;
        // period of 512 ticks keeps every width below it
        wr(ADDR_INC_UPPER, 8'h00);
        wr(ADDR_INC_HIGH, 8'h08);
        wr(ADDR_INC_LOW, 8'h00);
        wr(ADDR_CONTROL, 8'h81);
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CLOCK_SEL, {c[2:0], 5'h01});
            // first pulse after a code change may be mixed
            run_len(n);
            run_len(n);
            check_count("pulse width", 1 << c, n);
        end
    endtask : pulse_widths

    task automatic clock_sources;
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_INC_UPPER, 8'h04);
        wr(ADDR_INC_HIGH, 8'h00);
        wr(ADDR_INC_LOW, 8'h00);
        wr(ADDR_CONTROL, 8'h80);
        wr(ADDR_CLOCK_SEL, 8'h00);
        run_len(n);
        run_len(n);
        check_count("fast oscillator run", 32, n);
        wr(ADDR_CLOCK_SEL, 8'h02);
        run_len(n);
        run_len(n);
        check_count("logic cell run", 48, n);
        wr(ADDR_CLOCK_SEL, 8'h03);
        bus(1'b0, ADDR_ACC_UPPER, 8'h00);
        q2 = q;
        repeat (20) @(posedge i_clk);
        rd_chk("reserved code no ticks", ADDR_ACC_UPPER, q2);
    endtask : clock_sources

    task automatic interrupt_path;
        wr(ADDR_CLOCK_SEL, 8'h01);
        wr(ADDR_IRQ_EN, 8'h01);
        run_len(n);
        check_byte("irq raised", 8'h01, {7'h0, irq});
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_IRQ_STAT, 8'h00);
        rd_chk("status read only", ADDR_IRQ_STAT, 8'h01);
        wr(ADDR_IRQ_EN, 8'h00);
        @(negedge i_clk);
        check_byte("irq masked", 8'h00, {7'h0, irq});
        wr(ADDR_IRQ_EN, 8'h01);
        wr(ADDR_IRQ_CLR, 8'h01);
        rd_chk("flag cleared", ADDR_IRQ_STAT, 8'h00);
        @(negedge i_clk);
        check_byte("irq after clear", 8'h00, {7'h0, irq});
    endtask : interrupt_path

    // ----------------------------------------------------------------
    // main sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        reset_values();
        field_access();
        toggle_and_buffer();
        readback_and_invert();
        pulse_widths();
        clock_sources();
        interrupt_path();
        final_report();
    end

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches = mismatches + 1;
            final_report();
        end
    end
endmodule : numerically_controlled_oscillator_test

`default_nettype wire

// >>> verification/osc_consumer_model.sv
// downstream model: clock sources for the oscillator and an edge counter on its output
`timescale 1ns/1ps
`default_nettype none

module osc_consumer_model (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    // oscillator output as seen downstream
    input  wire logic i_osc_out,
    // clock sources
    output var  logic o_fast_osc,
    output var  logic o_logic_cell_three_output,
    // observation
    output var  int   o_rise_count
);
    logic last_q;

    // ----------------------------------------------------------------
    // free-running sources, phase unrelated to i_clk
    // ----------------------------------------------------------------
    // periods of 8 and 12 system cycles keep each phase well over two cycles
    initial begin
        o_fast_osc = 1'b0;
        #3;
        forever #40 o_fast_osc = ~o_fast_osc;
    end

    initial begin
        o_logic_cell_three_output = 1'b0;
        #7;
        forever #60 o_logic_cell_three_output = ~o_logic_cell_three_output;
    end

    // ----------------------------------------------------------------
    // rising edges of the output
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            last_q       <= 1'b0;
            o_rise_count <= 0;
        end else begin
            last_q <= i_osc_out;
            if (i_osc_out && !last_q)
                o_rise_count <= o_rise_count + 1;
        end
    end
endmodule : osc_consumer_model

`default_nettype wire
